// File: src/exc_regs_pkg.sv
// Shared constants for the exception and status control registers.
// Assumes a single processor clock; control-register numbers index a 32-entry space.

package exc_regs_pkg;

  // ****************************************
  // Control register numbers
  // ****************************************
  localparam int          CTL_SEL_W      = 5;
  localparam logic [4:0]  CTL_STATUS     = 5'h00;
  localparam logic [4:0]  CTL_SAVED_EXC  = 5'h01;
  localparam logic [4:0]  CTL_SAVED_BRK  = 5'h02;
  localparam logic [4:0]  CTL_IRQ_MASK   = 5'h03;
  localparam logic [4:0]  CTL_IRQ_PEND   = 5'h04;
  localparam logic [4:0]  CTL_PROC_ID    = 5'h05;
  localparam logic [4:0]  CTL_CAUSE      = 5'h07;
  localparam logic [4:0]  CTL_SAVED_SHD  = 5'h08;

  // ****************************************
  // Status word layout, shared by the saved copies
  // ****************************************
  localparam int ST_GIE     = 0;
  localparam int ST_USER    = 1;
  localparam int ST_EXC     = 2;
  localparam int ST_IH      = 3;
  localparam int ST_IL_LO   = 4;
  localparam int ST_IL_HI   = 9;
  localparam int ST_CRS_LO  = 10;
  localparam int ST_CRS_HI  = 15;
  localparam int ST_PRS_LO  = 16;
  localparam int ST_PRS_HI  = 21;
  localparam int ST_NMI     = 22;
  localparam int ST_SET_INTERRUPT_ENABLE    = 23;
  localparam int SET_W      = 6;

  // ****************************************
  // Cause register layout and reset values
  // ****************************************
  localparam int          CAUSE_LO   = 2;
  localparam int          CAUSE_HI   = 6;
  localparam int          CAUSE_W    = 5;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [31:0] WORD_ONES  = 32'hffff_ffff;
  localparam logic [4:0]  CAUSE_ZERO = 5'h00;
  localparam logic [5:0]  SET_ZERO   = 6'h00;

endpackage : exc_regs_pkg

// File: src/saved_status_if.sv
// Carrier between the status logic and one saved-status register.
// Assumes capture and software write are single-cycle strobes on clk_sys.

`timescale 1ns/100ps
`default_nettype none

interface saved_status_if;
  logic        capture;
  logic [31:0] capture_data;
  logic        sw_write;
  logic [31:0] sw_data;
  logic [31:0] value;

  modport owner (output capture, output capture_data, output sw_write, output sw_data, input value);
  modport store (input capture, input capture_data, input sw_write, input sw_data, output value);
endinterface : saved_status_if

`default_nettype wire

// File: src/saved_status_reg.sv
// One saved copy of the status word: hardware capture and software read/write.
// Assumes the owner never needs a software write to beat a capture.

`timescale 1ns/100ps
`default_nettype none

module saved_status_reg (
  input  wire logic     clk_sys,
  input  wire logic     resetn,
  saved_status_if.store port_s
);

  typedef struct packed {
    logic [31:0] word;
  } saved_state_t;

  saved_state_t state;
  saved_state_t next_state;

  // ****************************************
  // Capture wins so an event copy is never lost
  // ****************************************
  always_comb begin
    next_state = state;
    if (port_s.capture) begin
      next_state.word = port_s.capture_data;
    end else if (port_s.sw_write) begin
      next_state.word = port_s.sw_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= '{word: exc_regs_pkg::WORD_ZERO};
    end else begin
      state <= next_state;
    end
  end

  assign port_s.value = state.word;

  a_capture_copies_word: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    port_s.capture |=> port_s.value == $past(port_s.capture_data))
    else $error("saved status did not take the captured word");

  a_write_stores_word: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    port_s.sw_write && !port_s.capture |=> port_s.value == $past(port_s.sw_data))
    else $error("saved status did not take the software word");

endmodule : saved_status_reg

`default_nettype wire

// File: src/exception_status_regs.sv
// Status, saved-status, interrupt mask/pending, identifier and cause registers.
// Assumes the pipeline raises at most the documented events and control accesses
// as single-cycle strobes; interrupt request lines are synchronous to clk_sys.
//
// What this block does
// - User mode bit selects user, zero without MMU
// - Global enable gates internal and maskable interrupts
// - Unimplemented status fields read and act zero
// - Default-high unimplemented field reads and acts one
// - Current register set is read-only
// - Exception saved status read/write, resets zero
// - Interrupt with flag clear saves status
// - Shadow set request saves into shadow copy
// - Exception return restores by current set
// - Break saved status read/write, resets zero
// - Break copies status into break copy
// - Break return restores status from break copy
// - Mask bit n enables request line n
// - Mask reads zero without internal controller
// - Pending bit follows request line level
// - Pending writes ignored; exists with controller
// - Processor identifier constant, writes ignored
// - Cause register present with MMU/MPU or option
// - Certain exceptions record highest-priority cause code
// - Cause unchanged on break or interrupt
// - Any exception sets the exception flag when the MMU is built; without it the flag reads zero

`timescale 1ns/100ps
`default_nettype none

module exception_status_regs #(
  parameter bit          HAS_MMU        = 1'b0,
  parameter bit          HAS_MPU        = 1'b0,
  parameter bit          HAS_EIC        = 1'b0,
  parameter bit          HAS_SHADOW     = 1'b0,
  parameter bit          HAS_IIC        = 1'b1,
  parameter bit          HAS_EXTRA_INFO = 1'b0,
  parameter logic [31:0] PROC_ID        = 32'h0000_0000, // Arbitrary value, set per processor
  parameter int          IRQ_LINES      = 32
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 resetn,
  input  wire logic [exc_regs_pkg::CTL_SEL_W-1:0]   ctl_sel,
  input  wire logic                                 ctl_wr,
  input  wire logic                                 ctl_rd,
  input  wire logic [31:0]                          ctl_wdata,
  output var  logic [31:0]                          ctl_rdata,
  input  wire logic                                 take_exception,
  input  wire logic                                 cause_record,
  input  wire logic [exc_regs_pkg::CAUSE_W-1:0]     cause_code,
  input  wire logic                                 take_interrupt,
  input  wire logic                                 interrupt_external,
  input  wire logic                                 interrupt_nmi,
  input  wire logic [exc_regs_pkg::SET_W-1:0]       interrupt_reg_set,
  input  wire logic [exc_regs_pkg::SET_W-1:0]       interrupt_level_req,
  input  wire logic                                 take_break,
  input  wire logic                                 do_eret,
  input  wire logic                                 do_bret,
  input  wire logic [IRQ_LINES-1:0]                 interrupt_request_line,
  output var  logic [31:0]                          status_word,
  output var  logic                                 internal_irq_request
);

  // ****************************************
  // Build-time field presence
  // ****************************************
  localparam bit CAUSE_PRESENT = HAS_MMU || HAS_MPU || HAS_EXTRA_INFO;

  function automatic logic [31:0] keep_bits();
    logic [31:0] m;
    m = exc_regs_pkg::WORD_ZERO;
    m[exc_regs_pkg::ST_GIE] = 1'b1;
    if (HAS_MMU) begin
      m[exc_regs_pkg::ST_USER] = 1'b1;
      m[exc_regs_pkg::ST_EXC] = 1'b1;
    end
    if (HAS_EIC) begin
      m[exc_regs_pkg::ST_IH] = 1'b1;
      m[exc_regs_pkg::ST_IL_HI:exc_regs_pkg::ST_IL_LO] = exc_regs_pkg::SET_ZERO - 6'h01;
      m[exc_regs_pkg::ST_NMI] = 1'b1;
    end
    if (HAS_SHADOW) begin
      m[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO] = exc_regs_pkg::SET_ZERO - 6'h01;
      m[exc_regs_pkg::ST_PRS_HI:exc_regs_pkg::ST_PRS_LO] = exc_regs_pkg::SET_ZERO - 6'h01;
    end
    if (HAS_EIC && HAS_SHADOW) begin
      m[exc_regs_pkg::ST_SET_INTERRUPT_ENABLE] = 1'b1;
    end
    return m;
  endfunction : keep_bits

  function automatic logic [31:0] force_bits();
    logic [31:0] m;
    m = exc_regs_pkg::WORD_ZERO;
    if (!(HAS_EIC && HAS_SHADOW)) begin
      m[exc_regs_pkg::ST_SET_INTERRUPT_ENABLE] = 1'b1;
    end
    return m;
  endfunction : force_bits

  localparam logic [31:0] KEEP_MASK  = keep_bits();
  localparam logic [31:0] FORCE_MASK = force_bits();

  typedef struct packed {
    logic [31:0]                      status;
    logic [IRQ_LINES-1:0]             irq_mask;
    logic [IRQ_LINES-1:0]             pending;
    logic [exc_regs_pkg::CAUSE_W-1:0] cause;
    logic [31:0]                      rdata;
    logic                             irq_request;
  } core_state_t;

  core_state_t                        state;
  core_state_t                        next_state;
  logic [31:0]                        st;
  logic [31:0]                        rd_word;
  logic [exc_regs_pkg::SET_W-1:0]     cur_set;
  logic                               shadow_req;

  saved_status_if exc_if ();
  saved_status_if brk_if ();
  saved_status_if shd_if ();

  saved_status_reg u_saved_exc (.clk_sys(clk_sys), .resetn(resetn), .port_s(exc_if.store));
  saved_status_reg u_saved_brk (.clk_sys(clk_sys), .resetn(resetn), .port_s(brk_if.store));
  saved_status_reg u_saved_shd (.clk_sys(clk_sys), .resetn(resetn), .port_s(shd_if.store));

  // ****************************************
  // Next-state logic
  // ****************************************
  // Event priority: break, exception, interrupt, eret, bret, software write.
  // The pipeline is expected to raise one at a time; priority only keeps it defined.
  always_comb begin
    next_state = state;
    st = state.status;
    cur_set = state.status[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO];
    shadow_req = HAS_SHADOW && (interrupt_reg_set != exc_regs_pkg::SET_ZERO);
    rd_word = exc_regs_pkg::WORD_ZERO;
    exc_if.capture = 1'b0;
    brk_if.capture = 1'b0;
    shd_if.capture = 1'b0;
    exc_if.capture_data = state.status;
    brk_if.capture_data = state.status;
    shd_if.capture_data = state.status;
    exc_if.sw_data = ctl_wdata;
    brk_if.sw_data = ctl_wdata;
    shd_if.sw_data = ctl_wdata;
    exc_if.sw_write = ctl_wr && (ctl_sel == exc_regs_pkg::CTL_SAVED_EXC);
    brk_if.sw_write = ctl_wr && (ctl_sel == exc_regs_pkg::CTL_SAVED_BRK);
    shd_if.sw_write = ctl_wr && (ctl_sel == exc_regs_pkg::CTL_SAVED_SHD);

    if (take_break) begin
      brk_if.capture = 1'b1;
      st[exc_regs_pkg::ST_EXC] = 1'b1;
      st[exc_regs_pkg::ST_GIE] = 1'b0;
      st[exc_regs_pkg::ST_USER] = 1'b0;
      st[exc_regs_pkg::ST_PRS_HI:exc_regs_pkg::ST_PRS_LO] = cur_set;
    end else if (take_exception) begin
      if (!state.status[exc_regs_pkg::ST_EXC]) begin
        exc_if.capture = 1'b1;
      end
      st[exc_regs_pkg::ST_EXC] = 1'b1;
      st[exc_regs_pkg::ST_GIE] = 1'b0;
      st[exc_regs_pkg::ST_USER] = 1'b0;
      st[exc_regs_pkg::ST_PRS_HI:exc_regs_pkg::ST_PRS_LO] = cur_set;
      st[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO] = exc_regs_pkg::SET_ZERO;
      if (cause_record && CAUSE_PRESENT) begin
        next_state.cause = cause_code;
      end
    end else if (take_interrupt) begin
      // Cause is left alone here
      if (shadow_req) begin
        shd_if.capture = 1'b1;
      end else if (!state.status[exc_regs_pkg::ST_EXC]) begin
        exc_if.capture = 1'b1;
      end
      st[exc_regs_pkg::ST_EXC] = 1'b1;
      st[exc_regs_pkg::ST_GIE] = 1'b0;
      st[exc_regs_pkg::ST_USER] = 1'b0;
      st[exc_regs_pkg::ST_IH] = interrupt_external;
      st[exc_regs_pkg::ST_NMI] = interrupt_nmi;
      if (interrupt_external) begin
        st[exc_regs_pkg::ST_IL_HI:exc_regs_pkg::ST_IL_LO] = interrupt_level_req;
      end
      st[exc_regs_pkg::ST_PRS_HI:exc_regs_pkg::ST_PRS_LO] = cur_set;
      st[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO] = interrupt_reg_set;
    end else if (do_eret) begin
      st = (cur_set == exc_regs_pkg::SET_ZERO) ? exc_if.value : shd_if.value;
    end else if (do_bret) begin
      st = brk_if.value;
    end else if (ctl_wr && (ctl_sel == exc_regs_pkg::CTL_STATUS)) begin
      st = ctl_wdata;
      st[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO] = cur_set;
    end

    // Unimplemented fields cannot hold a stray value, so behaviour follows the read value
    next_state.status = (st & KEEP_MASK) | FORCE_MASK;

    if (HAS_IIC) begin
      if (ctl_wr && (ctl_sel == exc_regs_pkg::CTL_IRQ_MASK)) begin
        next_state.irq_mask = ctl_wdata[IRQ_LINES-1:0];
      end
      next_state.pending = interrupt_request_line;
    end else begin
      next_state.irq_mask = '0;
      next_state.pending = '0;
    end

    // Request is formed from next values so it always matches the visible registers
    next_state.irq_request = next_state.status[exc_regs_pkg::ST_GIE]
                             && |(next_state.pending & next_state.irq_mask);

    if (ctl_sel == exc_regs_pkg::CTL_STATUS) begin
      rd_word = state.status;
    end else if (ctl_sel == exc_regs_pkg::CTL_SAVED_EXC) begin
      rd_word = exc_if.value;
    end else if (ctl_sel == exc_regs_pkg::CTL_SAVED_BRK) begin
      rd_word = brk_if.value;
    end else if (ctl_sel == exc_regs_pkg::CTL_SAVED_SHD && HAS_SHADOW) begin
      rd_word = shd_if.value;
    end else if (ctl_sel == exc_regs_pkg::CTL_IRQ_MASK) begin
      rd_word = 32'(state.irq_mask);
    end else if (ctl_sel == exc_regs_pkg::CTL_IRQ_PEND) begin
      rd_word = 32'(state.pending);
    end else if (ctl_sel == exc_regs_pkg::CTL_PROC_ID) begin
      rd_word = PROC_ID;
    end else if (ctl_sel == exc_regs_pkg::CTL_CAUSE) begin
      rd_word[exc_regs_pkg::CAUSE_HI:exc_regs_pkg::CAUSE_LO] = state.cause;
    end
    if (ctl_rd) begin
      next_state.rdata = rd_word;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= '{status: FORCE_MASK, cause: exc_regs_pkg::CAUSE_ZERO, rdata: exc_regs_pkg::WORD_ZERO, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign ctl_rdata            = state.rdata;
  assign status_word          = state.status;
  assign internal_irq_request = state.irq_request;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_break;
    take_break;
  endsequence

  sequence s_exception;
    take_exception && !take_break;
  endsequence

  sequence s_interrupt;
    take_interrupt && !take_exception && !take_break;
  endsequence

  sequence s_eret;
    do_eret && !take_interrupt && !take_exception && !take_break;
  endsequence

  sequence s_bret;
    do_bret && !do_eret && !take_interrupt && !take_exception && !take_break;
  endsequence

  sequence s_status_write;
    ctl_wr && ctl_sel == exc_regs_pkg::CTL_STATUS && !do_bret && !do_eret
    && !take_interrupt && !take_exception && !take_break;
  endsequence

  a_user_mode_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    !HAS_MMU |-> !status_word[exc_regs_pkg::ST_USER])
    else $error("user mode bit set without memory management");
  a_global_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !status_word[exc_regs_pkg::ST_GIE] |-> !internal_irq_request)
    else $error("interrupt requested while globally disabled");
  a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    (status_word & ~KEEP_MASK & ~FORCE_MASK) == exc_regs_pkg::WORD_ZERO)
    else $error("unimplemented status field reads nonzero");
  a_default_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(HAS_EIC && HAS_SHADOW) |-> status_word[exc_regs_pkg::ST_SET_INTERRUPT_ENABLE])
    else $error("default-high field reads zero");
  a_set_readonly: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_status_write |=> $stable(status_word[exc_regs_pkg::ST_CRS_HI:exc_regs_pkg::ST_CRS_LO]))
    else $error("software write changed current register set");
  a_irq_saves_exc: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_interrupt ##0 (!shadow_req && !status_word[exc_regs_pkg::ST_EXC])
    |=> exc_if.value == $past(status_word))
    else $error("interrupt did not save status");
  a_irq_saves_shd: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_interrupt ##0 shadow_req |=> shd_if.value == $past(status_word) && $stable(exc_if.value))
    else $error("shadow request did not save into shadow copy");
  a_eret_restore: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_eret |=> status_word == (($past(cur_set) == exc_regs_pkg::SET_ZERO ? $past(exc_if.value)
                               : $past(shd_if.value)) & KEEP_MASK | FORCE_MASK))
    else $error("exception return restored wrong copy");
  a_break_saves: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_break |=> brk_if.value == $past(status_word))
    else $error("break did not save status");
  a_bret_restore: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_bret |=> status_word == ($past(brk_if.value) & KEEP_MASK | FORCE_MASK))
    else $error("break return did not restore status");
  a_mask_gates: assert property (@(posedge clk_sys) disable iff (!resetn)
    internal_irq_request |-> |(state.pending & state.irq_mask))
    else $error("request without an enabled pending line");
  a_mask_absent: assert property (@(posedge clk_sys) disable iff (!resetn)
    !HAS_IIC |-> state.irq_mask == '0 && state.pending == '0)
    else $error("mask or pending nonzero without controller");
  a_pending_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    HAS_IIC |=> state.pending == $past(interrupt_request_line))
    else $error("pending view lags request lines");
  a_cause_record: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_exception ##0 (cause_record && CAUSE_PRESENT) |=> state.cause == $past(cause_code))
    else $error("cause not recorded");
  a_cause_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_break or s_interrupt) |=> $stable(state.cause))
    else $error("cause changed on break or interrupt");
  a_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_break or s_exception or s_interrupt) ##0 HAS_MMU |=> status_word[exc_regs_pkg::ST_EXC])
    else $error("exception flag not set on exception");

endmodule : exception_status_regs

`default_nettype wire

// File: sim/irq_source.sv
// Peripheral model: drives the interrupt request lines as levels.
// Assumes the bench sets the wanted levels; lines move just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module irq_source (
  input  wire logic        clk_sys,
  input  wire logic [31:0] level_req,
  output var  logic [31:0] lines
);
  // Registered so the block never sees a line change on its own sampling edge
  initial lines = 32'h0000_0000;
  always @(posedge clk_sys) begin
    lines <= level_req;
  end
endmodule : irq_source
`default_nettype wire

// File: sim/exception_status_regs_bench.sv
// Self-checking bench for the exception and status register block.
// Assumes irq_source and the design sources are compiled first.
`timescale 1ns/100ps
`default_nettype none
module exception_status_regs_bench;
  logic        clk_sys;
  logic        resetn;
  logic        ctl_wr;
  logic        ctl_rd;
  logic        cause_record;
  logic        internal_irq_request;
  logic [4:0]  ctl_sel;
  logic [4:0]  cause_code;
  logic [4:0]  ev;
  logic [1:0]  irq_kind;
  logic [31:0] ctl_wdata;
  logic [31:0] ctl_rdata;
  logic [31:0] status_word;
  logic [31:0] irq_req;
  logic [31:0] lines;
  int          n_fail;
  int          checks;

  // Shadow sets and the external controller are not built, so set and level inputs are tied
  exception_status_regs #(.HAS_MMU(1'b1), .PROC_ID(32'h0000_1234)) dut (
    .clk_sys, .resetn, .ctl_sel, .ctl_wr, .ctl_rd, .ctl_wdata, .ctl_rdata,
    .take_exception(ev[3]), .cause_record, .cause_code, .take_interrupt(ev[2]),
    .interrupt_external(irq_kind[1]), .interrupt_nmi(irq_kind[0]), .interrupt_reg_set(6'h00),
    .interrupt_level_req(6'h00), .take_break(ev[4]), .do_eret(ev[1]), .do_bret(ev[0]),
    .interrupt_request_line(lines), .status_word, .internal_irq_request
  );
  irq_source peer (.clk_sys, .level_req(irq_req), .lines);

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    ctl_sel = s;
    ctl_wdata = d;
    ctl_wr = 1'b1;
    @(negedge clk_sys);
    ctl_wr = 1'b0;
    // One idle edge so a following call never re-raises the strobe in the same step
    @(negedge clk_sys);
  endtask : wr
  task automatic rc(input logic [4:0] s, input logic [31:0] exp);
    ctl_sel = s;
    ctl_rd = 1'b1;
    @(negedge clk_sys);
    ctl_rd = 1'b0;
    chk(ctl_rdata, exp);
    @(negedge clk_sys);
  endtask : rc
  task automatic pulse(input logic [4:0] v);
    ev = v;
    @(negedge clk_sys);
    ev = 5'h00;
    @(negedge clk_sys);
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(status_word, 32'h0080_0000);
    rc(exc_regs_pkg::CTL_SAVED_EXC, 32'h0000_0000);
    rc(exc_regs_pkg::CTL_SAVED_BRK, 32'h0000_0000);
    rc(exc_regs_pkg::CTL_CAUSE, 32'h0000_0000);
  endtask : t_reset
  task automatic t_status();
    // Current set and level bits are offered but must not stick
    wr(exc_regs_pkg::CTL_STATUS, 32'h0000_fff3);
    chk(status_word, 32'h0080_0003);
    wr(exc_regs_pkg::CTL_SAVED_EXC, 32'ha5a5_5a5a);
    rc(exc_regs_pkg::CTL_SAVED_EXC, 32'ha5a5_5a5a);
    wr(exc_regs_pkg::CTL_SAVED_BRK, 32'h5a5a_a5a5);
    rc(exc_regs_pkg::CTL_SAVED_BRK, 32'h5a5a_a5a5);
  endtask : t_status
  task automatic t_break();
    pulse(5'h10);
    chk(status_word, 32'h0080_0004);
    rc(exc_regs_pkg::CTL_SAVED_BRK, 32'h0080_0003);
    pulse(5'h01);
    chk(status_word, 32'h0080_0003);
    rc(exc_regs_pkg::CTL_CAUSE, 32'h0000_0000);
  endtask : t_break
  task automatic t_irq();
    // External nonmaskable kind offered; those status fields are not built here
    irq_kind = 2'b11;
    pulse(5'h04);
    irq_kind = 2'b00;
    rc(exc_regs_pkg::CTL_SAVED_EXC, 32'h0080_0003);
    chk(status_word, 32'h0080_0004);
    wr(exc_regs_pkg::CTL_SAVED_EXC, 32'h0080_0001);
    // Exception flag is set now, so a nested interrupt must keep the copy
    pulse(5'h04);
    rc(exc_regs_pkg::CTL_SAVED_EXC, 32'h0080_0001);
    pulse(5'h02);
    chk(status_word, 32'h0080_0001);
    rc(exc_regs_pkg::CTL_CAUSE, 32'h0000_0000);
  endtask : t_irq
  task automatic t_cause();
    cause_code = 5'h1f;
    cause_record = 1'b1;
    pulse(5'h08);
    cause_record = 1'b0;
    chk(status_word, 32'h0080_0004);
    rc(exc_regs_pkg::CTL_CAUSE, 32'h0000_007c);
    wr(exc_regs_pkg::CTL_CAUSE, 32'h0000_0000);
    rc(exc_regs_pkg::CTL_CAUSE, 32'h0000_007c);
  endtask : t_cause
  task automatic t_lines();
    wr(exc_regs_pkg::CTL_STATUS, 32'h0000_0001);
    irq_req = 32'h8000_0001;
    wr(exc_regs_pkg::CTL_IRQ_MASK, 32'h8000_0000);
    @(negedge clk_sys);
    rc(exc_regs_pkg::CTL_IRQ_PEND, 32'h8000_0001);
    chk({31'h0, internal_irq_request}, 32'h0000_0001);
    wr(exc_regs_pkg::CTL_IRQ_PEND, 32'h0000_0000);
    rc(exc_regs_pkg::CTL_IRQ_PEND, 32'h8000_0001);
    rc(exc_regs_pkg::CTL_IRQ_MASK, 32'h8000_0000);
    wr(exc_regs_pkg::CTL_IRQ_MASK, 32'h0000_0002);
    chk({31'h0, internal_irq_request}, 32'h0000_0000);
    wr(exc_regs_pkg::CTL_IRQ_MASK, 32'h0000_0001);
    chk({31'h0, internal_irq_request}, 32'h0000_0001);
    wr(exc_regs_pkg::CTL_STATUS, 32'h0000_0000);
    chk({31'h0, internal_irq_request}, 32'h0000_0000);
    irq_req = 32'h0000_0000;
    wr(exc_regs_pkg::CTL_PROC_ID, 32'h0000_0000);
    rc(exc_regs_pkg::CTL_PROC_ID, 32'h0000_1234);
    rc(exc_regs_pkg::CTL_IRQ_PEND, 32'h0000_0000);
  endtask : t_lines

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    resetn = 1'b0;
    ctl_wr = 1'b0;
    ctl_rd = 1'b0;
    ctl_sel = 5'h00;
    ctl_wdata = 32'h0000_0000;
    cause_record = 1'b0;
    cause_code = 5'h00;
    ev = 5'h00;
    irq_req = 32'h0000_0000;
    irq_kind = 2'b00;
    n_fail = 0;
    checks = 0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset();
    t_status();
    t_break();
    t_irq();
    t_cause();
    t_lines();
    end_of_test();
  end
  // About 80 cycles of work; the limit leaves wide margin
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule : exception_status_regs_bench
`default_nettype wire
